/* trc_defs.vh */
// Constants of the timer run and overflow control register
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH
`define TRC_SFR_PAGE 4'h0
`define TRC_ADDR 8'h88
`define TRC_RESET 8'h00
`define TRC_BIT_T1_FLAG 3'h7
`define TRC_BIT_T1_RUN 3'h6
`define TRC_BIT_T0_FLAG 3'h5
`define TRC_BIT_T0_RUN 3'h4
`define TRC_MODE_13BIT 2'h0
`define TRC_MODE_16BIT 2'h1
`define TRC_MODE_RELOAD 2'h2
`define TRC_MODE_SPLIT 2'h3
`endif

/* trc_sync.v */
// Two-stage synchroniser for a single input from outside the clock domain
`default_nettype none
module trc_sync
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire d,
  output wire q
);
  reg stage1;
  reg stage2;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else if (clk_en)
    begin
      stage1 <= d;
      stage2 <= stage1;
    end
  end

  assign q = stage2;
endmodule
`default_nettype wire

/* trc_control.v */
// Timer run and overflow control register with timer run-enable and flag logic
`default_nettype none
`include "trc_defs.vh"

// Functional notes
// (R1) The register answers at page 0x0, address 0x88 to byte writes and to single-bit writes.
// (R2) An overflow of timer 1 sets the timer1 overflow flag whether or not its interrupt is enabled.
// (R3) The timer1 overflow flag clears on a software write of zero or when the timer 1 interrupt is vectored.
// (R4) An overflow of timer 0 sets the timer0 overflow flag whether or not its interrupt is enabled.
// (R5) The timer0 overflow flag clears on a software write of zero or when the timer 0 interrupt is vectored.
// (R6) The timer1 run bit starts and stops timer 1 counting without touching its count; in split mode timer 1 counts whenever timer1_mode is not split.
// (R7) Timer 0 counts when its run bit is set and either the gate qualifier is 0 or the gate input is active.
// (R8) In 13-bit mode the wrap from 0x1FFF to 0x0000 is the overflow that sets the flag.
// (R9) In split mode the timer1 run bit enables the timer0 upper byte, whose overflow sets the timer1 flag.
module trc_control
(
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [3:0] sfr_page,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_bit_wr,
  input wire [2:0] sfr_bit_sel,
  input wire sfr_bit_val,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output wire sfr_sel,
  input wire [1:0] timer0_mode,
  input wire [1:0] timer1_mode,
  input wire timer0_gate_qualifier,
  input wire timer1_gate_qualifier,
  input wire external_gate_input,
  input wire external_gate1_input,
  input wire timer0_gate_active_high,
  input wire timer1_gate_active_high,
  input wire timer0_overflow,
  input wire timer1_overflow,
  input wire timer0_upper_byte_overflow,
  input wire timer0_vector_ack,
  input wire timer1_vector_ack,
  input wire [3:0] ext_int_bits,
  output wire timer0_count_en,
  output wire timer0_upper_byte_count_en,
  output wire timer1_count_en,
  output wire [3:0] ext_int_wdata,
  output wire ext_int_we,
  output reg timer0_overflow_flag,
  output reg timer1_overflow_flag,
  output reg timer0_run_bit,
  output reg timer1_run_bit
);
  // ----------------------------------------
  // Gate input synchronisers
  // ----------------------------------------
  wire gate_in0_sync;
  wire gate_in1_sync;

  trc_sync u_sync0
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(external_gate_input),
    .q(gate_in0_sync)
  );

  trc_sync u_sync1
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(external_gate1_input),
    .q(gate_in1_sync)
  );

  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  wire hit;
  wire byte_we;
  wire bit_we;
  reg [7:0] cur;
  reg [7:0] wr_val;
  reg [7:0] wr_mask;

  assign hit = (sfr_page == `TRC_SFR_PAGE) && (sfr_addr == `TRC_ADDR); // [R1]
  assign sfr_sel = hit;
  assign byte_we = hit && sfr_wr && clk_en;
  assign bit_we = hit && sfr_bit_wr && !sfr_wr && clk_en;

  always @*
  begin
    cur = {timer1_overflow_flag, timer1_run_bit, timer0_overflow_flag, timer0_run_bit, ext_int_bits};
    wr_val = 8'h00;
    wr_mask = 8'h00;
    if (byte_we)
    begin
      wr_val = sfr_wdata; // [R1]
      wr_mask = 8'hff;
    end
    else if (bit_we)
    begin
      wr_val = cur; // [R1]
      wr_val[sfr_bit_sel] = sfr_bit_val;
      wr_mask[sfr_bit_sel] = 1'b1;
    end
  end

  assign ext_int_we = byte_we || (bit_we && (sfr_bit_sel < `TRC_BIT_T0_RUN));
  assign ext_int_wdata = wr_val[3:0];

  always @*
  begin
    sfr_rdata = hit ? cur : 8'h00;
  end

  // ----------------------------------------
  // Overflow event sources
  // ----------------------------------------
  wire split;
  wire t0_event;
  wire t1_event;

  assign split = (timer0_mode == `TRC_MODE_SPLIT);
  // Counter reports its own wrap (0x1FFF->0 in 13-bit mode) on timer0_overflow
  assign t0_event = timer0_overflow; // [R4] [R8]
  // In split mode timer 1 may not set its flag; the upper byte of timer 0 does
  assign t1_event = split ? timer0_upper_byte_overflow : timer1_overflow; // [R2] [R8] [R9]

  // ----------------------------------------
  // Overflow flags
  // ----------------------------------------
  reg next_t0_flag;
  reg next_t1_flag;

  // Write, then vector clear, then overflow: a wrap in a clearing cycle is never lost
  always @*
  begin
    next_t0_flag = timer0_overflow_flag;
    if (wr_mask[`TRC_BIT_T0_FLAG])
    begin
      next_t0_flag = wr_val[`TRC_BIT_T0_FLAG]; // [R5]
    end
    if (timer0_vector_ack)
    begin
      next_t0_flag = 1'b0; // [R5]
    end
    if (t0_event)
    begin
      next_t0_flag = 1'b1; // [R4]
    end
  end

  always @*
  begin
    next_t1_flag = timer1_overflow_flag;
    if (wr_mask[`TRC_BIT_T1_FLAG])
    begin
      next_t1_flag = wr_val[`TRC_BIT_T1_FLAG]; // [R3]
    end
    if (timer1_vector_ack)
    begin
      next_t1_flag = 1'b0; // [R3]
    end
    if (t1_event)
    begin
      next_t1_flag = 1'b1; // [R2]
    end
  end

  // ----------------------------------------
  // Run bits
  // ----------------------------------------
  reg next_t0_run;
  reg next_t1_run;

  // Run bits change only on a write; they never touch the count itself
  always @*
  begin
    next_t0_run = timer0_run_bit;
    next_t1_run = timer1_run_bit;
    if (wr_mask[`TRC_BIT_T0_RUN])
    begin
      next_t0_run = wr_val[`TRC_BIT_T0_RUN]; // [R7]
    end
    if (wr_mask[`TRC_BIT_T1_RUN])
    begin
      next_t1_run = wr_val[`TRC_BIT_T1_RUN]; // [R6]
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      timer0_run_bit <= 1'b0;
      timer1_run_bit <= 1'b0;
    end
    else if (clk_en)
    begin
      timer0_overflow_flag <= next_t0_flag;
      timer1_overflow_flag <= next_t1_flag;
      timer0_run_bit <= next_t0_run;
      timer1_run_bit <= next_t1_run; // [R6]
    end
  end

  // ----------------------------------------
  // Count enables
  // ----------------------------------------
  wire t0_gate_ok;
  wire t1_gate_ok;

  // Polarity input picks which synchronised pin level counts as active
  assign t0_gate_ok = !timer0_gate_qualifier || (gate_in0_sync == timer0_gate_active_high);
  assign t1_gate_ok = !timer1_gate_qualifier || (gate_in1_sync == timer1_gate_active_high);
  assign timer0_count_en = timer0_run_bit && t0_gate_ok; // [R7]
  assign timer0_upper_byte_count_en = split && timer1_run_bit; // [R9]
  // Enable only gates counting; the count itself lives in the datapath and is never cleared here
  assign timer1_count_en = split ? (timer1_mode != `TRC_MODE_SPLIT) : (timer1_run_bit && t1_gate_ok); // [R6]
endmodule
`default_nettype wire

/* trc_control_sva.sv */
// Checker of the timer control register ports
`default_nettype none
module trc_control_sva(
  input wire logic clk, sys_rst, clk_en, sfr_wr, sfr_bit_wr, sfr_sel, timer0_overflow, timer1_overflow,
  input wire logic timer0_vector_ack, timer0_gate_qualifier, timer0_count_en, timer0_upper_byte_count_en,
  input wire logic timer0_overflow_flag, timer1_overflow_flag, timer0_run_bit, timer1_run_bit,
  input wire logic [7:0] sfr_wdata, sfr_rdata,
  input wire logic [1:0] timer0_mode,
  input wire logic [3:0] ext_int_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_t0s; clk_en && timer0_overflow |=> timer0_overflow_flag; endproperty
  a_t0s: assert property (p_t0s) else $error("timer0 flag not set");
  property p_t1s; clk_en && timer1_overflow && timer0_mode != 2'h3 |=> timer1_overflow_flag; endproperty
  a_t1s: assert property (p_t1s) else $error("timer1 flag not set");
  property p_t0c; clk_en && timer0_vector_ack && !timer0_overflow |=> !timer0_overflow_flag; endproperty
  a_t0c: assert property (p_t0c) else $error("timer0 flag not cleared");
  property p_wr; clk_en && sfr_wr && sfr_sel |=> timer1_run_bit == $past(sfr_wdata[6])
    && timer0_run_bit == $past(sfr_wdata[4]); endproperty
  a_wr: assert property (p_wr) else $error("run bits wrong");
  property p_hold; !sfr_wr && !sfr_bit_wr |=> $stable(timer1_run_bit); endproperty
  a_hold: assert property (p_hold) else $error("timer1 run bit moved");
  property p_en0; !timer0_gate_qualifier |-> timer0_count_en == timer0_run_bit; endproperty
  a_en0: assert property (p_en0) else $error("t0 enable wrong");
  property p_sp; timer0_mode == 2'h3 |-> timer0_upper_byte_count_en == timer1_run_bit; endproperty
  a_sp: assert property (p_sp) else $error("split enable wrong");
  property p_rd; sfr_rdata == (sfr_sel ? {timer1_overflow_flag, timer1_run_bit, timer0_overflow_flag,
    timer0_run_bit, ext_int_bits} : 8'h00); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  c_wr: cover property (clk_en && sfr_wr && sfr_sel);
  c_ov: cover property (timer0_overflow_flag && timer1_overflow_flag);
  c_sp: cover property (timer0_mode == 2'h3 && timer0_upper_byte_count_en);
endmodule
bind trc_control trc_control_sva u_sva(.*);
`default_nettype wire

/* trc_control_tb_top.sv */
// Self-checking bench of the timer control register
`default_nettype none
module trc_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk=0,sys_rst=1,clk_en=1,sfr_wr=0,sfr_bit_wr=0,sfr_bit_val=0,timer0_gate_qualifier=0;
  logic timer1_gate_qualifier=0,external_gate_input=0,external_gate1_input=0,timer0_gate_active_high=1;
  logic timer1_gate_active_high=1,timer0_overflow=0,timer1_overflow=0,timer0_upper_byte_overflow=0;
  logic timer0_vector_ack=0,timer1_vector_ack=0,sfr_sel,ext_int_we,timer0_count_en,timer1_count_en;
  logic timer0_upper_byte_count_en,timer0_overflow_flag,timer1_overflow_flag,timer0_run_bit,timer1_run_bit;
  logic [3:0] sfr_page=0,ext_int_bits=4'h5,ext_int_wdata;
  logic [7:0] sfr_addr=8'h88,sfr_wdata=0,sfr_rdata;
  logic [2:0] sfr_bit_sel=0;
  logic [1:0] timer0_mode=0,timer1_mode=0;
  // Expected flags in bits 26:23, inputs of one cycle below
  logic [26:0] rows[14]='{27'h2d00050,27'h3c04000,27'h7c02000,27'h6c00800,27'h3c04400,27'h3f00000,
    27'h3900000,27'h2cd0000,27'h0ce0000,27'h1504000,27'h34e8300,27'h3402300,27'h7401300,27'h0500000};
  int fails=0,checked=0;
  trc_control dut(.*);
  always #20 clk=~clk;
  task check(string n,logic [7:0] s,e);
    checked++;
    if(s!==e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h",n,e,s);
    end
  endtask
  task end_sim;
    $display("checked %0d fails %0d",checked,fails);
    if(fails==0&&checked>0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #10000 fails++;
    end_sim;
  end
  initial
  begin
    repeat(16) @(posedge clk);
    #1 sys_rst=0;
    foreach(rows[i])
    begin
      {clk_en,sfr_page[0],sfr_wr,sfr_bit_wr,sfr_bit_sel,sfr_bit_val,timer0_overflow,timer1_overflow,
        timer0_upper_byte_overflow,timer0_vector_ack,timer1_vector_ack,timer0_mode,sfr_wdata}=rows[i][22:0];
      @(posedge clk) #1;
      check("flags",{4'h0,timer1_overflow_flag,timer1_run_bit,timer0_overflow_flag,timer0_run_bit},
        {4'h0,rows[i][26:23]});
    end
    sfr_wdata=8'h10;
    timer0_gate_qualifier=1;
    @(posedge clk) #1 sfr_wr=0;
    check("gate off",{7'h0,timer0_count_en},8'h00);
    external_gate_input=1;
    repeat(2) @(posedge clk);
    #1 check("gate on",{7'h0,timer0_count_en},8'h01);
    timer0_gate_active_high=0;
    repeat(2) @(posedge clk);
    #1 check("gate pol",{7'h0,timer0_count_en},8'h00);
    ext_int_bits=4'ha;
    timer0_mode=2'h3;
    #1 check("t1 split run",{7'h0,timer1_count_en},8'h01);
    check("upper off",{7'h0,timer0_upper_byte_count_en},8'h00);
    timer1_mode=2'h3;
    #1 check("t1 split stop",{7'h0,timer1_count_en},8'h00);
    timer0_mode=2'h0;
    timer1_mode=2'h0;
    sfr_bit_wr=1;
    sfr_bit_sel=3'h2;
    sfr_bit_val=1;
    #1 check("ext we",{7'h0,ext_int_we},8'h01);
    check("ext data",{4'h0,ext_int_wdata},8'h0e);
    sfr_bit_sel=3'h4;
    #1 check("ext we off",{7'h0,ext_int_we},8'h00);
    sfr_bit_wr=0;
    sfr_addr=8'h89;
    #1 check("miss",sfr_rdata,8'h00);
    check("miss sel",{7'h0,sfr_sel},8'h00);
    sfr_addr=8'h88;
    #1 check("read",sfr_rdata,8'h1a);
    sys_rst=1;
    #5 check("reset",sfr_rdata,8'h0a);
    end_sim;
  end
endmodule
`default_nettype wire
